/* File: design/adc_conversion_control.sv */
// conversion control for the eight-channel digitizer on the host I/O port
// What this block does
// - control write with bit 10 sets mode
// - mode bit zero unipolar, one bipolar
// - reset leaves the digitizer unipolar
// - channel number in bits two to zero
// - channel selection persists between conversions
// - control write bits 15, 12 start conversion
// - start sets busy for whole conversion
// - busy clears, result readable when done
// - start strobe follows host write through the two-flop synchroniser
// - busy readable in the status port
// - result read returns the stored sample, busy or not
// - unipolar result unsigned, top nibble zero
// - bipolar result sign extended
`timescale 1ns/1ns
module adc_conversion_control #(
  parameter int CONVERT_CYCLES = adc_ctrl_pkg::CONVERT_CYCLES,
  parameter int SAMPLE_W = adc_ctrl_pkg::SAMPLE_BITS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host I/O port, decoded to this block's 64-byte window
  input wire logic io_cs,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [5:0] io_addr,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // converter core
  output logic start_strobe,
  output logic [2:0] channel_number,
  output logic bipolar_mode,
  output logic conversion_busy_flag,
  input wire logic [SAMPLE_W-1:0] sample_data
);
  localparam int CNT_W = $clog2(CONVERT_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONVERT_CYCLES - 1);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  initial
  begin
    if (CONVERT_CYCLES < 1)
      $error("conversion time must be at least one cycle");
    if (SAMPLE_W < 1 || SAMPLE_W > 16)
      $error("sample width out of range");
  end
  typedef struct packed {
    adc_ctrl_pkg::io_req_t req_s1;
    adc_ctrl_pkg::io_req_t req_s2;
    logic wr_prev;
    adc_ctrl_pkg::conv_state_t state;
    logic [CNT_W-1:0] count;
    logic bipolar;
    logic [2:0] channel;
    logic start;
    logic [SAMPLE_W-1:0] sample;
    logic [SAMPLE_W-1:0] sample_s1;
    logic [15:0] rdata;
  } state_t;
  state_t cur_r;
  state_t cur_nxt;
  logic [15:0] result_word;
  logic write_edge;
  logic is_control;
  logic is_channel;
  logic mode_cmd;
  logic start_cmd;
  logic read_active;
  logic read_result;
  logic read_status;
  logic busy;
  logic conv_done;
  // ---------------------------------------------------------------
  // result formatting
  // ---------------------------------------------------------------
  adc_result_format #(
    .SAMPLE_W(SAMPLE_W)
  ) u_format (
    .sample(cur_r.sample),
    .bipolar(cur_r.bipolar),
    .word(result_word)
  );
  // ---------------------------------------------------------------
  // host write decode
  // ---------------------------------------------------------------
  // one event per rising edge of the synchronised strobe
  assign write_edge = cur_r.req_s2.cs & cur_r.req_s2.wr & ~cur_r.wr_prev;
  assign is_control = write_edge && (cur_r.req_s2.addr == adc_ctrl_pkg::OFS_CONTROL);
  assign is_channel = write_edge && (cur_r.req_s2.addr == adc_ctrl_pkg::OFS_CHANNEL);
  // mode field enabled by its bit
  assign mode_cmd = is_control && cur_r.req_s2.wdata[adc_ctrl_pkg::CTL_MODE_BIT];
  assign start_cmd = is_control
                     && cur_r.req_s2.wdata[adc_ctrl_pkg::CTL_VALUE_BIT]
                     && cur_r.req_s2.wdata[adc_ctrl_pkg::CTL_START_BIT];
  // ---------------------------------------------------------------
  // host read decode
  // ---------------------------------------------------------------
  assign read_active = cur_r.req_s2.cs && cur_r.req_s2.rd;
  assign read_result = read_active && (cur_r.req_s2.addr == adc_ctrl_pkg::OFS_RESULT);
  assign read_status = read_active && (cur_r.req_s2.addr == adc_ctrl_pkg::OFS_STATUS);
  // ---------------------------------------------------------------
  // conversion progress
  // ---------------------------------------------------------------
  // busy is the run state itself
  assign busy = cur_r.state == adc_ctrl_pkg::CONV_RUN;
  assign conv_done = busy && (cur_r.count == CNT_LAST);
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    cur_nxt = cur_r;
    // host inputs pass two flops first
    cur_nxt.req_s1 = '{cs: io_cs, rd: io_rd, wr: io_wr, addr: io_addr, wdata: io_wdata};
    cur_nxt.req_s2 = cur_r.req_s1;
    cur_nxt.sample_s1 = sample_data;
    cur_nxt.wr_prev = cur_r.req_s2.wr & cur_r.req_s2.cs;
    cur_nxt.start = 1'b0;
    if (mode_cmd)
    begin
      cur_nxt.bipolar = cur_r.req_s2.wdata[adc_ctrl_pkg::CTL_VALUE_BIT];
    end
    if (is_channel)
    begin
      cur_nxt.channel = cur_r.req_s2.wdata[2:0];
    end
    unique case (cur_r.state)
      adc_ctrl_pkg::CONV_IDLE:
      begin
        if (start_cmd)
        begin
          cur_nxt.start = 1'b1;
          cur_nxt.state = adc_ctrl_pkg::CONV_RUN;
          cur_nxt.count = '0;
        end
      end
      adc_ctrl_pkg::CONV_RUN:
      begin
        // sample taken as busy falls
        if (conv_done)
        begin
          cur_nxt.state = adc_ctrl_pkg::CONV_IDLE;
          cur_nxt.sample = cur_r.sample_s1;
        end
        else
        begin
          cur_nxt.count = cur_r.count + CNT_W'(1);
        end
      end
    endcase
    // read data stands only while a mapped read is held
    cur_nxt.rdata = 16'h0000;
    if (read_result)
    begin
      cur_nxt.rdata = result_word;
    end
    else if (read_status)
    begin
      cur_nxt.rdata[adc_ctrl_pkg::STS_BUSY_BIT] = busy;
      cur_nxt.rdata[adc_ctrl_pkg::STS_BIPOLAR_BIT] = cur_r.bipolar;
    end
  end
  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_r.req_s1 <= '0;
      cur_r.req_s2 <= '0;
      cur_r.wr_prev <= 1'b0;
      cur_r.state <= adc_ctrl_pkg::CONV_IDLE;
      cur_r.count <= '0;
      cur_r.bipolar <= adc_ctrl_pkg::RESET_MODE_BIPOLAR;
      cur_r.channel <= adc_ctrl_pkg::RESET_CHANNEL;
      cur_r.start <= 1'b0;
      cur_r.sample <= '0;
      cur_r.sample_s1 <= '0;
      cur_r.rdata <= 16'h0000;
    end
    else
    begin
      cur_r <= cur_nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs, each straight from a flop
  // ---------------------------------------------------------------
  assign io_rdata = cur_r.rdata;
  assign start_strobe = cur_r.start;
  assign channel_number = cur_r.channel;
  assign bipolar_mode = cur_r.bipolar;
  assign conversion_busy_flag = busy;
endmodule

/* File: inc/adc_ctrl_pkg.sv */
// constants and types for the digitizer conversion control block
package adc_ctrl_pkg;
  // ---------------------------------------------------------------
  // register offsets within the I/O block
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_RESULT = 6'h10;
  localparam logic [5:0] OFS_CHANNEL = 6'h16;
  localparam logic [5:0] OFS_STATUS = 6'h16;
  localparam logic [5:0] OFS_CONTROL = 6'h28;
  // ---------------------------------------------------------------
  // control port fields
  // ---------------------------------------------------------------
  localparam int CTL_VALUE_BIT = 15;
  localparam int CTL_START_BIT = 12;
  localparam int CTL_MODE_BIT = 10;
  // ---------------------------------------------------------------
  // status port fields
  // ---------------------------------------------------------------
  localparam int STS_BUSY_BIT = 3;
  localparam int STS_BIPOLAR_BIT = 0;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic RESET_MODE_BIPOLAR = 1'b0;
  localparam logic [2:0] RESET_CHANNEL = 3'h0;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONVERT_TIME_NS = 9000;
  localparam int CONVERT_CYCLES = CONVERT_TIME_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_BITS = 12;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} conv_state_t;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } io_req_t;
endpackage

/* File: design/adc_result_format.sv */
// formats a raw 12-bit sample by conversion mode
`timescale 1ns/1ns
module adc_result_format #(
  parameter int SAMPLE_W = 12
) (
  // sample in
  input wire logic [SAMPLE_W-1:0] sample,
  input wire logic bipolar,
  // formatted word
  output logic [15:0] word
);
  initial
  begin
    if (SAMPLE_W < 1 || SAMPLE_W > 16)
      $error("sample width out of range");
  end
  always_comb
  begin
    if (bipolar)
      word = 16'({{(16 - SAMPLE_W){sample[SAMPLE_W-1]}}, sample});
    else
      word = 16'({{(16 - SAMPLE_W){1'b0}}, sample});
  end
endmodule

/* File: tb/adc_conversion_control_props.sv */
// port checker for the conversion control block
`timescale 1ns/1ns
module adc_conversion_control_props (
  // host side
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic io_cs,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [5:0] io_addr,
  input wire logic [15:0] io_wdata,
  input wire logic [15:0] io_rdata,
  // converter side
  input wire logic start_strobe,
  input wire logic [2:0] channel_number,
  input wire logic bipolar_mode,
  input wire logic conversion_busy_flag
);
  wire logic ctl = io_cs && io_addr == 6'h28;
  wire logic chn = io_cs && io_addr == 6'h16;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  chk_reset_state: assert property ($rose(reset_n) |-> !bipolar_mode && !conversion_busy_flag)
    else $error("state after reset wrong");
  chk_start_cause: assert property ($rose(io_wr) && ctl && io_wdata[15] && io_wdata[12] && !conversion_busy_flag
    |-> ##[2:4] start_strobe)
    else $error("start missing");
  chk_start_pulse: assert property (start_strobe |=> !start_strobe)
    else $error("start too long");
  chk_busy_rise: assert property ($rose(conversion_busy_flag) |-> start_strobe)
    else $error("busy without start");
  chk_busy_span: assert property (start_strobe |-> conversion_busy_flag[*8] ##1 !conversion_busy_flag)
    else $error("busy span wrong");
  chk_mode_write: assert property ($rose(io_wr) && ctl && io_wdata[10] |-> ##5 bipolar_mode == $past(io_wdata[15], 5))
    else $error("mode not taken");
  chk_chan_write: assert property ($rose(io_wr) && chn |-> ##5 channel_number == $past(io_wdata[2:0], 5))
    else $error("channel not taken");
  chk_rdata_idle: assert property ((!io_rd)[*4] |-> io_rdata == 16'h0000)
    else $error("read data not idle");
endmodule
bind adc_conversion_control adc_conversion_control_props i_props (.core_clk, .reset_n, .io_cs, .io_rd, .io_wr,
  .io_addr, .io_wdata, .io_rdata, .start_strobe, .channel_number, .bipolar_mode, .conversion_busy_flag);

/* File: tb/adc_core_model.sv */
// converter core model: takes a new sample at each start
`timescale 1ns/1ns
module adc_core_model (
  // controls
  input wire logic core_clk,
  input wire logic start_strobe,
  input wire logic [11:0] next_sample,
  // sample out
  output logic [11:0] sample_data = 12'h5A5
);
  always @(posedge core_clk)
    if (start_strobe)
      sample_data <= next_sample;
endmodule

/* File: tb/adc_conversion_control_tb_top.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ns
module adc_conversion_control_tb_top;
  logic core_clk, reset_n, io_cs, io_rd, io_wr, start_strobe, bipolar_mode, conversion_busy_flag;
  logic [5:0] io_addr;
  logic [15:0] io_wdata, io_rdata;
  logic [2:0] channel_number;
  logic [11:0] sample_data, next_sample;
  logic [11:0] smp [3] = '{12'hFFF, 12'h800, 12'h7FF};
  int err_count, n_checks;
  adc_conversion_control #(.CONVERT_CYCLES(8)) i_dut (.core_clk, .reset_n, .io_cs, .io_rd, .io_wr, .io_addr,
    .io_wdata, .io_rdata, .start_strobe, .channel_number, .bipolar_mode, .conversion_busy_flag, .sample_data);
  adc_core_model i_core (.core_clk, .start_strobe, .next_sample, .sample_data);
  initial
  begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(negedge core_clk);
    {io_cs, io_wr, io_addr, io_wdata} = {2'b11, a, d};
    repeat (2) @(negedge core_clk);
    {io_cs, io_wr} = 2'b00;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic rd(logic [5:0] a, logic [15:0] exp, string name);
    @(negedge core_clk);
    {io_cs, io_rd, io_addr} = {2'b11, a};
    repeat (5) @(negedge core_clk);
    chk(name, exp, io_rdata);
    {io_cs, io_rd} = 2'b00;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic conv(logic [11:0] s);
    next_sample = s;
    wr(6'h28, 16'h9000);
    chk("busy", 16'h0001, {15'h0, conversion_busy_flag});
    for (int k = 0; k < 40 && conversion_busy_flag !== 1'b0; k++) @(negedge core_clk);
    chk("busy", 16'h0000, {15'h0, conversion_busy_flag});
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #40000;
    err_count++;
    complete_run();
  end
  initial
  begin
    {reset_n, io_cs, io_rd, io_wr, io_addr, io_wdata, next_sample} = '0;
    repeat (2) @(negedge core_clk);
    reset_n = 1;
    rd(6'h16, 16'h0000, "status");
    rd(6'h2A, 16'h0000, "unmapped");
    $display("reset test done");
    for (int c = 0; c < 8; c++)
    begin
      wr(6'h16, 16'(c));
      chk("channel", 16'(c), {13'h0, channel_number});
    end
    // settling gap before the first start
    repeat (16) @(negedge core_clk);
    $display("channel test done");
    for (int m = 0; m < 2; m++)
    begin
      wr(6'h28, {m[0], 15'h0400});
      rd(6'h16, {15'h0, m[0]}, "status");
      foreach (smp[i])
      begin
        conv(smp[i]);
        rd(6'h10, m ? {{4{smp[i][11]}}, smp[i]} : {4'h0, smp[i]}, "result");
      end
    end
    chk("channel", 16'h0007, {13'h0, channel_number});
    $display("conversion test done");
    complete_run();
  end
endmodule
